// ---- pkg/mtl_defines.svh ----
// Notes on behaviour
// - Each mission sample logged from 1000h upward.
// - Full log: wrap to 1000h or stop.
// - Control bit 3 selects wraparound.
// - 63 sixteen-bit bins from 0800h, low first.
// - Bin index is sample byte shifted right two.
// - Bins saturate at 65535.
// - Threshold reached sets hot or cold flag.
// - Excursion start writes stamp, then duration byte.
// - Duration at 255 opens next entry.
// - Back in band stops duration; recrossing opens entry.
// - Cold entries at 0220h, hot at 0250h.
// - First write at 200h-213h only ends mission.
// - Status read-only except mission active bit.
// - Writes at 215h and above ignored.
// - Bit 0 enables timer alarm search answer.
// - Bit 1 enables hot alarm search answer.
// - Bit 2 enables cold alarm search answer.
// - Bit 4 low permits mission start.
// - Bit 6 arms clear; next command drops it.
// - Armed clear wipes memories, counters, delay, rate.
// - Bit 7 high halts oscillator.
// - Target address bytes and ending status layout.
// - Sample byte is twice Celsius plus 80, clamped.
// - Nonzero rate write starts mission, sets flag.
`ifndef MTL_DEFINES_SVH
`define MTL_DEFINES_SVH

// Memory areas
`define MTL_LOG_BASE 16'h1000
`define MTL_LOG_END 16'h1800
`define MTL_LOG_LAST 11'h7ff
`define MTL_HIST_BASE 16'h0800
`define MTL_HIST_END 16'h087d
`define MTL_HIST_MAX 16'hffff
`define MTL_COLD_BASE 16'h0220
`define MTL_HOT_BASE 16'h0250
`define MTL_EXC_SPAN 16'h0030
`define MTL_EXC_ENTRIES 4'hc
`define MTL_DUR_MAX 8'hff

// Register page
`define MTL_REG_WR_FIRST 16'h0200
`define MTL_REG_WR_LAST 16'h0213
`define MTL_REG_LOW_TH 16'h020b
`define MTL_REG_HIGH_TH 16'h020c
`define MTL_REG_RATE 16'h020d
`define MTL_REG_CTRL 16'h020e
`define MTL_REG_DELAY_LO 16'h0212
`define MTL_REG_DELAY_HI 16'h0213
`define MTL_REG_FLAGS 16'h0214
`define MTL_REG_STAMP 16'h0215
`define MTL_REG_STAMP_LAST 16'h0219
`define MTL_REG_COUNT 16'h021a
`define MTL_REG_COUNT_LAST 16'h021c

// Control bits
`define MTL_CB_TIMER_SRCH 0
`define MTL_CB_HOT_SRCH 1
`define MTL_CB_COLD_SRCH 2
`define MTL_CB_WRAP 3
`define MTL_CB_EN_N 4
`define MTL_CB_ZERO 5
`define MTL_CB_ARM 6
`define MTL_CB_OSC_HALT 7
`define MTL_CTRL_RST 8'h10

// Status bits
`define MTL_SB_MIP 5

// Temperature coding
`define MTL_TEMP_OFFSET 11'sh050
`define MTL_TEMP_MAX 8'hfa

`endif

// ---- pkg/mtl_pkg.sv ----
package mtl_pkg;

	// One host access to the memory map
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mtl_acc_s;

	// Ending status byte of a memory command
	typedef struct packed {
		logic copy_done_flag;
		logic zero_bit;
		logic partial_byte_flag;
		logic [4:0] end_off;
	} mtl_es_s;

endpackage : mtl_pkg

// ---- rtl/mtl_excursion.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mtl_defines.svh"

module mtl_excursion (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sample side
	input wire logic wipe,
	input wire logic step,
	input wire logic hit,
	input wire logic [23:0] stamp,
	// Read side
	input wire logic [5:0] rd_idx,
	output logic [7:0] rd_byte
);

	logic [23:0] stamp_mem [0:11]; // Entry time stamps
	logic [7:0] dur_mem [0:11]; // Entry durations
	logic [3:0] idx; // Current or next entry
	logic open; // Excursion entry counting
	logic [3:0] next_idx; // Entry for a new stamp

	// Fresh entry goes after a full counter, else at idx
	always_comb begin
		next_idx = open ? 4'(idx + 4'h1) : idx;
	end

	// Entry bookkeeping
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx <= 4'h0;
			open <= 1'b0;
		end else if (wipe) begin
			idx <= 4'h0;
			open <= 1'b0;
		end else if (step && hit && (!open || dur_mem[idx] == `MTL_DUR_MAX)) begin
			idx <= (next_idx > `MTL_EXC_ENTRIES) ? `MTL_EXC_ENTRIES : next_idx;
			open <= next_idx < `MTL_EXC_ENTRIES;
		end else if (step && !hit && open) begin
			open <= 1'b0;
			idx <= 4'(idx + 4'h1);
		end
	end

	// Stamp and duration storage
	always_ff @(posedge clk) begin
		if (wipe) begin
			for (int i = 0; i < 12; i++) begin
				stamp_mem[i] <= 24'h000000;
				dur_mem[i] <= 8'h00;
			end
		end else if (step && hit) begin
			if (!open || dur_mem[idx] == `MTL_DUR_MAX) begin
				if (next_idx < `MTL_EXC_ENTRIES) begin
					stamp_mem[next_idx] <= stamp;
					dur_mem[next_idx] <= 8'h01;
				end
			end else begin
				dur_mem[idx] <= 8'(dur_mem[idx] + 8'h01);
			end
		end
	end

	// Byte view: stamp low first, duration above it
	always_comb begin
		rd_byte = 8'h00;
		if (rd_idx[5:2] < `MTL_EXC_ENTRIES) begin
			case (rd_idx[1:0])
				2'h0: rd_byte = stamp_mem[rd_idx[5:2]][7:0];
				2'h1: rd_byte = stamp_mem[rd_idx[5:2]][15:8];
				2'h2: rd_byte = stamp_mem[rd_idx[5:2]][23:16];
				default: rd_byte = dur_mem[rd_idx[5:2]];
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_EXC_OPEN: assert property (step && hit && !open && !wipe && idx < `MTL_EXC_ENTRIES
		|=> open && dur_mem[$past(idx)] == 8'h01) else $error("new excursion entry not opened");
	AST_EXC_CLOSE: assert property (step && !hit && open && !wipe
		|=> !open && idx == $past(idx) + 4'h1) else $error("excursion not closed");

endmodule : mtl_excursion

`default_nettype wire

// ---- rtl/mtl_logger.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mtl_defines.svh"

module mtl_logger (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host memory access
	input wire mtl_pkg::mtl_acc_s acc,
	output logic [7:0] rdata,
	// Memory function commands
	input wire logic cmd_exec,
	input wire logic cmd_is_clear,
	input wire logic ta_load,
	input wire logic [15:0] ta_value,
	input wire logic es_load,
	input wire mtl_pkg::mtl_es_s es_in,
	output logic [7:0] target_addr_low,
	output logic [7:0] target_addr_high,
	output logic [7:0] end_offset_status,
	// Temperature converter
	input wire logic sample_valid,
	input wire logic signed [9:0] sample_raw,
	// Time of day side
	input wire logic timer_alarm,
	input wire logic [39:0] rtc_stamp,
	// Status out
	output logic mission_active,
	output logic search_match,
	output logic osc_run
);

	logic [7:0] ctrl; // Mission control byte
	logic [7:0] low_th; // Cold threshold
	logic [7:0] high_th; // Hot threshold
	logic [7:0] rate; // Sample rate
	logic [15:0] delay; // Start delay
	logic [39:0] start_stamp; // Mission start stamp
	logic [23:0] sample_count; // Mission samples
	logic timer_alarm_flag; // Timer alarm seen in mission
	logic hot_alarm_flag; // Hot threshold reached
	logic cold_alarm_flag; // Cold threshold reached
	logic mem_cleared; // Clear done, no mission since
	logic arm_fresh; // Arm write was the last access
	logic [10:0] log_ptr; // Next log slot
	logic log_full; // Log filled once
	logic [7:0] log_mem [0:2047]; // Sample log
	logic [15:0] hist [0:62]; // Histogram bins
	logic alarm_sync; // Synchronised timer alarm
	logic alarm_prev; // Alarm level last cycle
	logic [7:0] temp; // Encoded sample byte
	logic [5:0] bin; // Histogram bin of sample
	logic step; // Sample accepted this cycle
	logic in_wr_range; // Address in writable page
	logic end_by_write; // Write ends the mission
	logic reg_write; // Register write takes effect
	logic start; // Mission start this cycle
	logic wipe; // Memory clear this cycle
	logic log_write; // Sample stored in log
	logic [5:0] cold_idx; // Cold area byte index
	logic [5:0] hot_idx; // Hot area byte index
	logic [7:0] cold_byte; // Cold area read data
	logic [7:0] hot_byte; // Hot area read data
	logic [7:0] flags; // Status byte view
	logic [7:0] next_rdata; // Read data mux

	// Raw half-degree reading to clamped byte
	function automatic logic [7:0] enc_temp(input logic signed [9:0] raw);
		logic signed [10:0] v;
		v = 11'(raw) + `MTL_TEMP_OFFSET;
		if (v < 11'sh000) begin
			return 8'h00;
		end else if (v > $signed({3'h0, `MTL_TEMP_MAX})) begin
			return `MTL_TEMP_MAX;
		end
		return v[7:0];
	endfunction : enc_temp

	// Bin counter step that holds at full scale
	function automatic logic [15:0] sat_inc(input logic [15:0] h);
		return (h == `MTL_HIST_MAX) ? h : 16'(h + 16'h0001);
	endfunction : sat_inc

	// Timer alarm crosses from the clock side
	mtl_sync u_alarm_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(timer_alarm),
		.dout(alarm_sync)
	);

	// Sample and access decode
	always_comb begin
		temp = enc_temp(sample_raw);
		bin = temp[7:2];
		osc_run = !ctrl[`MTL_CB_OSC_HALT];
		step = sample_valid && mission_active && osc_run;
		log_write = step && (!log_full || ctrl[`MTL_CB_WRAP]);
		in_wr_range = acc.addr >= `MTL_REG_WR_FIRST && acc.addr <= `MTL_REG_WR_LAST;
		end_by_write = acc.wr && in_wr_range && mission_active;
		reg_write = acc.wr && in_wr_range && !mission_active;
		start = reg_write && acc.addr == `MTL_REG_RATE && acc.wdata != 8'h00
			&& !ctrl[`MTL_CB_EN_N];
		wipe = cmd_exec && cmd_is_clear && ctrl[`MTL_CB_ARM] && arm_fresh;
		cold_idx = 6'(acc.addr - `MTL_COLD_BASE);
		hot_idx = 6'(acc.addr - `MTL_HOT_BASE);
	end

	// Control byte; memory command drops the arm bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `MTL_CTRL_RST;
		end else if (reg_write && acc.addr == `MTL_REG_CTRL) begin
			ctrl <= acc.wdata & ~(8'h01 << `MTL_CB_ZERO);
		end else if (cmd_exec) begin
			ctrl[`MTL_CB_ARM] <= 1'b0;
		end
	end

	// Arm stays usable only until any other access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_fresh <= 1'b0;
		end else if (reg_write && acc.addr == `MTL_REG_CTRL) begin
			arm_fresh <= acc.wdata[`MTL_CB_ARM];
		end else if (acc.wr || acc.rd || cmd_exec) begin
			arm_fresh <= 1'b0;
		end
	end

	// Thresholds, rate and start delay
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_th <= 8'h00;
			high_th <= 8'h00;
			rate <= 8'h00;
			delay <= 16'h0000;
		end else if (wipe) begin
			rate <= 8'h00;
			delay <= 16'h0000;
		end else if (reg_write) begin
			// Only the first write of a mission is swallowed
			case (acc.addr)
				`MTL_REG_LOW_TH: low_th <= acc.wdata;
				`MTL_REG_HIGH_TH: high_th <= acc.wdata;
				`MTL_REG_RATE: rate <= acc.wdata;
				`MTL_REG_DELAY_LO: delay[7:0] <= acc.wdata;
				`MTL_REG_DELAY_HI: delay[15:8] <= acc.wdata;
				default: ;
			endcase
		end
	end

	// Mission active flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mission_active <= 1'b0;
		end else if (start) begin
			mission_active <= 1'b1;
		end else if (end_by_write) begin
			mission_active <= 1'b0;
		end else if (acc.wr && acc.addr == `MTL_REG_FLAGS && !acc.wdata[`MTL_SB_MIP]) begin
			mission_active <= 1'b0;
		end
	end

	// Mission start stamp and sample counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_stamp <= 40'h0000000000;
			sample_count <= 24'h000000;
		end else if (wipe) begin
			start_stamp <= 40'h0000000000;
			sample_count <= 24'h000000;
		end else begin
			if (start) begin
				start_stamp <= rtc_stamp;
			end
			if (step) begin
				sample_count <= 24'(sample_count + 24'h000001);
			end
		end
	end

	// Sticky alarm flags; only a memory clear drops them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_alarm_flag <= 1'b0;
			hot_alarm_flag <= 1'b0;
			cold_alarm_flag <= 1'b0;
			alarm_prev <= 1'b0;
		end else begin
			alarm_prev <= alarm_sync;
			if (alarm_sync && !alarm_prev && mission_active) begin
				timer_alarm_flag <= 1'b1;
			end else if (wipe) begin
				timer_alarm_flag <= 1'b0;
			end
			if (step && temp >= high_th) begin
				hot_alarm_flag <= 1'b1;
			end else if (wipe) begin
				hot_alarm_flag <= 1'b0;
			end
			if (step && temp <= low_th) begin
				cold_alarm_flag <= 1'b1;
			end else if (wipe) begin
				cold_alarm_flag <= 1'b0;
			end
		end
	end

	// Cleared flag set by a wipe, dropped by a start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_cleared <= 1'b0;
		end else if (wipe) begin
			mem_cleared <= 1'b1;
		end else if (start) begin
			mem_cleared <= 1'b0;
		end
	end

	// Log pointer and fill state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			log_ptr <= 11'h000;
			log_full <= 1'b0;
		end else if (wipe) begin
			log_ptr <= 11'h000;
			log_full <= 1'b0;
		end else if (log_write) begin
			log_ptr <= 11'(log_ptr + 11'h001);
			if (log_ptr == `MTL_LOG_LAST) begin
				log_full <= 1'b1;
			end
		end
	end

	// Log and histogram storage
	always_ff @(posedge clk) begin
		if (wipe) begin
			for (int i = 0; i < 2048; i++) begin
				log_mem[i] <= 8'h00;
			end
			for (int j = 0; j < 63; j++) begin
				hist[j] <= 16'h0000;
			end
		end else begin
			if (log_write) begin
				log_mem[log_ptr] <= temp;
			end
			if (step) begin
				hist[bin] <= sat_inc(hist[bin]);
			end
		end
	end

	// Cold and hot excursion records
	mtl_excursion u_cold (
		.clk(clk),
		.rst_n(rst_n),
		.wipe(wipe),
		.step(step),
		.hit(temp <= low_th),
		.stamp(sample_count),
		.rd_idx(cold_idx),
		.rd_byte(cold_byte)
	);
	mtl_excursion u_hot (
		.clk(clk),
		.rst_n(rst_n),
		.wipe(wipe),
		.step(step),
		.hit(temp >= high_th),
		.stamp(sample_count),
		.rd_idx(hot_idx),
		.rd_byte(hot_byte)
	);

	// Address registers of memory commands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			target_addr_low <= 8'h00;
			target_addr_high <= 8'h00;
			end_offset_status <= 8'h00;
		end else begin
			if (ta_load) begin
				target_addr_low <= ta_value[7:0];
				target_addr_high <= ta_value[15:8];
			end
			if (es_load) begin
				end_offset_status <= {es_in.copy_done_flag, 1'b0, es_in.partial_byte_flag,
					es_in.end_off};
			end
		end
	end

	// Read data selection over the map
	always_comb begin
		flags = {1'b1, mem_cleared, mission_active, 2'b00, cold_alarm_flag, hot_alarm_flag,
			timer_alarm_flag};
		next_rdata = 8'h00;
		if (acc.addr >= `MTL_LOG_BASE && acc.addr < `MTL_LOG_END) begin
			next_rdata = log_mem[acc.addr[10:0]];
		end else if (acc.addr >= `MTL_HIST_BASE && acc.addr <= `MTL_HIST_END) begin
			next_rdata = acc.addr[0] ? hist[acc.addr[6:1]][15:8] : hist[acc.addr[6:1]][7:0];
		end else if (acc.addr >= `MTL_COLD_BASE && acc.addr < `MTL_HOT_BASE) begin
			next_rdata = cold_byte;
		end else if (acc.addr >= `MTL_HOT_BASE && acc.addr < `MTL_HOT_BASE + `MTL_EXC_SPAN) begin
			next_rdata = hot_byte;
		end else if (acc.addr >= `MTL_REG_STAMP && acc.addr <= `MTL_REG_STAMP_LAST) begin
			next_rdata = start_stamp[8 * 3'(acc.addr - `MTL_REG_STAMP) +: 8];
		end else if (acc.addr >= `MTL_REG_COUNT && acc.addr <= `MTL_REG_COUNT_LAST) begin
			next_rdata = sample_count[8 * 2'(acc.addr - `MTL_REG_COUNT) +: 8];
		end else begin
			case (acc.addr)
				`MTL_REG_LOW_TH: next_rdata = low_th;
				`MTL_REG_HIGH_TH: next_rdata = high_th;
				`MTL_REG_RATE: next_rdata = rate;
				`MTL_REG_CTRL: next_rdata = ctrl;
				`MTL_REG_DELAY_LO: next_rdata = delay[7:0];
				`MTL_REG_DELAY_HI: next_rdata = delay[15:8];
				`MTL_REG_FLAGS: next_rdata = flags;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Read data register, loaded on a read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (acc.rd) begin
			rdata <= next_rdata;
		end
	end

	// Conditional search participation
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			search_match <= 1'b0;
		end else begin
			search_match <= (ctrl[`MTL_CB_TIMER_SRCH] && timer_alarm_flag)
				|| (ctrl[`MTL_CB_HOT_SRCH] && hot_alarm_flag)
				|| (ctrl[`MTL_CB_COLD_SRCH] && cold_alarm_flag);
		end
	end

	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence seq_arm;
		reg_write && acc.addr == `MTL_REG_CTRL && acc.wdata[`MTL_CB_ARM];
	endsequence
	sequence seq_clear_next;
		cmd_exec && cmd_is_clear && !acc.wr && !acc.rd;
	endsequence

	AST_LOG_SLOT: assert property (log_write && !wipe |=> log_mem[$past(log_ptr)] == $past(temp))
		else $error("sample not stored at log slot");
	AST_LOG_HOLD: assert property (step && log_full && !ctrl[`MTL_CB_WRAP] && !wipe
		|=> log_ptr == $past(log_ptr)) else $error("log advanced while full");
	AST_LOG_WRAP: assert property (log_write && log_ptr == `MTL_LOG_LAST && !wipe
		|=> log_ptr == 11'h000 && log_full) else $error("log did not wrap");
	AST_HIST_SAT: assert property (step && !wipe && hist[bin] == `MTL_HIST_MAX
		|=> hist[$past(bin)] == `MTL_HIST_MAX) else $error("bin left saturation");
	AST_HIST_INC: assert property (step && !wipe && hist[bin] < `MTL_HIST_MAX
		|=> hist[$past(bin)] == $past(hist[bin]) + 16'h0001) else $error("bin not bumped");
	AST_HOT_FLAG: assert property (step && temp >= high_th ##1 !wipe
		|-> hot_alarm_flag ##1 hot_alarm_flag) else $error("hot flag not held");
	AST_FIRST_WR: assert property (end_by_write && acc.addr == `MTL_REG_CTRL && !cmd_exec
		|=> !mission_active && ctrl == $past(ctrl)) else $error("first write changed ctrl");
	AST_STATUS_RO: assert property (acc.wr && acc.addr == `MTL_REG_FLAGS && !mission_active
		|=> !mission_active) else $error("status write started mission");
	AST_HIGH_IGN: assert property (acc.wr && acc.addr >= `MTL_REG_STAMP && !cmd_exec
		|=> $stable(ctrl) && $stable(low_th) && $stable(rate)) else $error("write above 214h");
	AST_START: assert property (start && !wipe |=> mission_active && !mem_cleared
		&& start_stamp == $past(rtc_stamp)) else $error("mission start failed");
	AST_ARM_DROP: assert property (cmd_exec && !acc.wr |=> !ctrl[`MTL_CB_ARM])
		else $error("arm bit kept after command");
	AST_WIPE: assert property (seq_arm ##1 seq_clear_next
		|=> sample_count == 24'h000000 && rate == 8'h00 && mem_cleared) else $error("clear lost");

endmodule : mtl_logger

`default_nettype wire

// ---- rtl/mtl_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module mtl_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in and out
	input wire logic din,
	output logic dout
);

	logic stage1; // First stage, read only by dout

	// Two-flop level synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end

endmodule : mtl_sync

`default_nettype wire

// ---- verif/mtl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mtl_host_model (
	// Clock
	input wire logic clk,
	// Host bus
	output var mtl_pkg::mtl_acc_s acc,
	input wire logic [7:0] rdata
);
	// Bus idle from time zero
	initial begin
		acc = '0;
	end

	// One byte write, one cycle strobe, then address and data scrambled
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		acc.wr = 1'b1;
		acc.addr = a;
		acc.wdata = d;
		@(negedge clk);
		acc.wr = 1'b0;
		acc.addr = ~a;
		acc.wdata = ~d;
	endtask : wr

	// One byte read, data taken after the strobe edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		acc.rd = 1'b1;
		acc.addr = a;
		@(negedge clk);
		acc.rd = 1'b0;
		acc.addr = ~a;
		d = rdata;
	endtask : rd
endmodule : mtl_host_model

`default_nettype wire

// ---- verif/mtl_logger_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module mtl_logger_tb_top;
	// Clock, reset and design signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mtl_pkg::mtl_acc_s acc;
	logic [7:0] rdata, ta_lo, ta_hi, es_out;
	logic cmd_exec = 1'b0;
	logic cmd_is_clear = 1'b0;
	logic ta_load = 1'b0;
	logic es_load = 1'b0;
	logic sample_valid = 1'b0;
	logic signed [9:0] sample_raw = 10'h000;
	logic timer_alarm = 1'b0;
	logic mission_active, search_match, osc_run;
	int n_mismatch = 0;
	int check_count = 0;
	// Expected bins, excursion bytes and counter as {address, byte}
	localparam logic [23:0] TBL [16] = '{24'h083202, 24'h084003, 24'h081401,
		24'h087c01, 24'h080001, 24'h087d00, 24'h025001, 24'h025100, 24'h025302,
		24'h025405, 24'h025702, 24'h022004, 24'h022301, 24'h022407, 24'h022701,
		24'h021a08};
	// Raw samples and their logged bytes
	localparam logic [9:0] RAW [8] = '{10'h014, 10'h030, 10'h030, 10'h014,
		10'h3d8, 10'h030, 10'h0c8, 10'h39c};
	localparam logic [7:0] LOG [8] = '{8'h64, 8'h80, 8'h80, 8'h64, 8'h28, 8'h80,
		8'hfa, 8'h00};

	// Clock generator, 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end

	mtl_host_model mtl_host_model_i (.clk(clk), .acc(acc), .rdata(rdata));

	mtl_logger mtl_logger_i (.clk(clk), .rst_n(rst_n), .acc(acc), .rdata(rdata),
		.cmd_exec(cmd_exec), .cmd_is_clear(cmd_is_clear), .ta_load(ta_load),
		.ta_value(16'h1234), .es_load(es_load), .es_in(8'hff),
		.target_addr_low(ta_lo), .target_addr_high(ta_hi), .end_offset_status(es_out),
		.sample_valid(sample_valid), .sample_raw(sample_raw), .timer_alarm(timer_alarm),
		.rtc_stamp(40'h0504030201), .mission_active(mission_active),
		.search_match(search_match), .osc_run(osc_run));

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// Compare one value
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// Read and compare
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		mtl_host_model_i.rd(a, d);
		chk(d, e);
	endtask : rc

	// One memory function command, issued at the falling edge the caller stands on
	task automatic cmd(input logic clr);
		cmd_exec = 1'b1;
		cmd_is_clear = clr;
		@(negedge clk);
		cmd_exec = 1'b0;
		cmd_is_clear = 1'b0;
	endtask : cmd

	// Armed clear as the very next access, no idle cycle between
	task automatic wipe();
		mtl_host_model_i.wr(16'h020e, 8'h40);
		cmd(1'b1);
	endtask : wipe

	// One converter result
	task automatic smp(input logic [9:0] r);
		@(negedge clk);
		sample_valid = 1'b1;
		sample_raw = r;
		@(negedge clk);
		sample_valid = 1'b0;
	endtask : smp

	// Watchdog at 20k cycles, well beyond the expected run of about 4.3k
	initial begin
		#400000;
		n_mismatch++;
		summarize();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		rc(16'h020e, 8'h10);
		chk({7'h0, osc_run}, 8'h01);
		mtl_host_model_i.wr(16'h020d, 8'h01);
		chk({7'h0, mission_active}, 8'h00);
		// Target address and ending status bytes
		@(negedge clk);
		ta_load = 1'b1;
		es_load = 1'b1;
		@(negedge clk);
		ta_load = 1'b0;
		es_load = 1'b0;
		chk(ta_lo, 8'h34);
		chk(ta_hi, 8'h12);
		chk(es_out, 8'hbf);
		wipe();
		rc(16'h020e, 8'h00);
		rc(16'h0214, 8'hc0);
		rc(16'h020d, 8'h00);
		mtl_host_model_i.wr(16'h020b, 8'h50);
		mtl_host_model_i.wr(16'h020c, 8'h70);
		mtl_host_model_i.wr(16'h020e, 8'h80);
		chk({7'h0, osc_run}, 8'h00);
		mtl_host_model_i.wr(16'h020e, 8'h06);
		chk({7'h0, osc_run}, 8'h01);
		mtl_host_model_i.wr(16'h020d, 8'h01);
		chk({7'h0, mission_active}, 8'h01);
		rc(16'h0215, 8'h01);
		// In band, hot twice, back, cold, hot, clamped hot, clamped cold
		for (int i = 0; i < 8; i++) begin
			smp(RAW[i]);
		end
		for (int i = 0; i < 8; i++) begin
			rc(16'h1000 + 16'(i), LOG[i]);
		end
		for (int i = 0; i < 16; i++) begin
			rc(TBL[i][23:8], TBL[i][7:0]);
		end
		rc(16'h0214, 8'ha6);
		chk({7'h0, search_match}, 8'h01);
		// First write only ends the mission, the next one lands
		mtl_host_model_i.wr(16'h020b, 8'h00);
		chk({7'h0, mission_active}, 8'h00);
		rc(16'h020b, 8'h50);
		mtl_host_model_i.wr(16'h020b, 8'h48);
		rc(16'h020b, 8'h48);
		mtl_host_model_i.wr(16'h0214, 8'hff);
		rc(16'h0214, 8'h86);
		mtl_host_model_i.wr(16'h021a, 8'h55);
		rc(16'h021a, 8'h08);
		// Arm spoiled by a read: clear does nothing, arm bit still drops
		mtl_host_model_i.wr(16'h020e, 8'h40);
		rc(16'h020e, 8'h40);
		cmd(1'b1);
		rc(16'h020d, 8'h01);
		rc(16'h020e, 8'h00);
		// Wraparound mission: 2049th sample lands at the log start
		wipe();
		rc(16'h1003, 8'h00);
		mtl_host_model_i.wr(16'h020e, 8'h08);
		mtl_host_model_i.wr(16'h020d, 8'h01);
		for (int i = 0; i < 2048; i++) begin
			smp(10'h00a);
		end
		smp(10'h014);
		rc(16'h1000, 8'h64);
		rc(16'h1001, 8'h5a);
		rc(16'h021a, 8'h01);
		rc(16'h021b, 8'h08);
		// Timer alarm in mission; search answer only once enabled
		timer_alarm = 1'b1;
		repeat (4) @(negedge clk);
		timer_alarm = 1'b0;
		rc(16'h0214, 8'ha1);
		chk({7'h0, search_match}, 8'h00);
		mtl_host_model_i.wr(16'h020e, 8'h01);
		mtl_host_model_i.wr(16'h020e, 8'h01);
		@(negedge clk);
		chk({7'h0, search_match}, 8'h01);
		// Restart with rollover off on a full log: nothing more is logged, the counter still advances
		mtl_host_model_i.wr(16'h020d, 8'h01);
		smp(10'h030);
		rc(16'h1001, 8'h5a);
		rc(16'h021a, 8'h02);
		summarize();
	end
endmodule : mtl_logger_tb_top

`default_nettype wire
